// >>> src/vtc_pkg.sv
package vtc_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] VTC_ADDR_CTRL = 8'h0d;
	localparam logic [7:0] VTC_ADDR_CHMUTE = 8'h0e;
	localparam logic [7:0] VTC_ADDR_VOL0 = 8'h0f;
	localparam logic [7:0] VTC_ADDR_VOL5 = 8'h14;
	localparam logic [7:0] VTC_ADDR_AMSTAT = 8'h30;
	localparam logic [7:0] VTC_ADDR_SEQSTAT = 8'h31;
	// ==========================================================
	// control register fields
	localparam int VTC_BIT_SINGLE_VOLUME_SELECT = 6;
	localparam int VTC_BIT_MODE_HI = 5;
	localparam int VTC_BIT_MODE_LO = 4;
	localparam int VTC_BIT_AUTO_STATIC_MUTE = 3;
	localparam int VTC_BIT_AUXMUTE = 2;
	localparam int VTC_BIT_RMPUP = 1;
	localparam int VTC_BIT_RMPDN = 0;
	localparam logic [7:0] VTC_CTRL_WMASK = 8'h7f;
	localparam logic [7:0] VTC_CTRL_RST = 8'h08;
	localparam logic [5:0] VTC_CHMUTE_RST = 6'h00;
	localparam logic [7:0] VTC_VOL_RST = 8'h00;
	// ==========================================================
	// transition modes
	localparam logic [1:0] VTC_MODE_IMM = 2'h0;
	localparam logic [1:0] VTC_MODE_ZC = 2'h1;
	localparam logic [1:0] VTC_MODE_RAMP = 2'h2;
	localparam logic [1:0] VTC_MODE_RAMPZC = 2'h3;
	// ==========================================================
	// levels in 1/8 dB units and counts in sample periods
	localparam int VTC_NCH = 6;
	localparam int VTC_DW = 24;
	localparam int VTC_AW = 11;
	localparam logic [10:0] VTC_ATT_MUTE = 11'h400;
	localparam logic [7:0] VTC_VOL_MAX = 8'hfe;
	localparam logic [5:0] VTC_ATT_OCTAVE = 6'h30;
	localparam logic [9:0] VTC_FINE_SLOPE = 10'h2ab;
	localparam logic [16:0] VTC_UNITY = 17'h10000;
	localparam int VTC_ZC_TIMEOUT = 512;
	localparam int VTC_AUTO_STATIC_MUTE_SAMPLES = 8192;
	// ==========================================================
	// state
	typedef enum logic [1:0] {
		VTC_IDLE = 2'b00,
		VTC_MUTING = 2'b01,
		VTC_APPLY = 2'b11,
		VTC_UNMUTE = 2'b10
	} vtc_seq_t;

	typedef struct packed {
		logic [10:0] att;
		logic [23:0] prev;
		logic [9:0] tmo;
		logic [12:0] stc;
		logic am;
		logic [23:0] out;
	} vtc_chan_st_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [5:0] chmute;
		logic [5:0][7:0] vol;
		logic [7:0] rdata;
		vtc_seq_t seq;
		logic kind_apply;
		logic pend_filt;
		logic pend_err;
		logic change_apply;
		logic valid;
		logic [23:0] aux;
		logic aux_valid;
		logic mute_ind;
	} vtc_top_st_t;
endpackage : vtc_pkg

// >>> src/vtc_chan.sv
`timescale 1ns/1ps
module vtc_chan (
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // sync reset, active low
	input wire logic smp_stb_i, // one pulse per sample period
	input wire logic [23:0] smp_i, // incoming sample
	input wire logic [1:0] mode_i, // transition mode
	input wire logic auto_static_mute_en_i, // auto-mute enable
	input wire logic [10:0] target_i, // requested attenuation
	input wire logic force_imm_i, // apply target at once
	output logic [23:0] smp_o, // scaled sample, registered
	output logic automute_o, // auto-mute state
	output logic settled_o // level reached its target
);
	vtc_pkg::vtc_chan_st_t s_q, s_d;
	logic [10:0] tgt;
	logic [10:0] step;
	logic stat;
	logic zc;
	logic hit;
	logic [4:0] shift;
	logic [5:0] fine;
	logic [16:0] mant;
	logic signed [41:0] prod;

	assign tgt = s_q.am ? vtc_pkg::VTC_ATT_MUTE : target_i;
	assign settled_o = (s_q.att == tgt);
	assign smp_o = s_q.out;
	assign automute_o = s_q.am;

	// ==========================================================
	// gain: octave shift plus linear fraction
	always_comb begin
		shift = 5'(s_q.att / 11'(vtc_pkg::VTC_ATT_OCTAVE));
		fine = 6'(s_q.att % 11'(vtc_pkg::VTC_ATT_OCTAVE));
		mant = vtc_pkg::VTC_UNITY - (17'(fine) * 17'(vtc_pkg::VTC_FINE_SLOPE));
		prod = ($signed(smp_i) * $signed({1'b0, mant})) >>> 16;
		prod = prod >>> shift;
	end

	// ==========================================================
	// level stepping and static detection
	always_comb begin
		s_d = s_q;
		stat = (smp_i == '0) || (smp_i == '1);
		zc = (smp_i[23] != s_q.prev[23]) || (smp_i == '0);
		hit = zc || (s_q.tmo == 10'(vtc_pkg::VTC_ZC_TIMEOUT - 1));
		step = (s_q.att < tgt) ? s_q.att + 11'h001 : s_q.att - 11'h001;
		if (mode_i == vtc_pkg::VTC_MODE_IMM && !settled_o) begin
			s_d.att = tgt;
		end
		if (smp_stb_i) begin
			s_d.prev = smp_i;
			if (!auto_static_mute_en_i || !stat) begin
				s_d.stc = '0;
				s_d.am = 1'b0;
			end else if (s_q.stc == 13'(vtc_pkg::VTC_AUTO_STATIC_MUTE_SAMPLES - 1)) begin
				s_d.am = 1'b1;
			end else begin
				s_d.stc = s_q.stc + 13'h0001;
			end
			if (!settled_o) begin
				case (mode_i)
					vtc_pkg::VTC_MODE_ZC: if (hit) s_d.att = tgt;
					vtc_pkg::VTC_MODE_RAMP: s_d.att = step;
					vtc_pkg::VTC_MODE_RAMPZC: if (hit) s_d.att = step;
					default: s_d.att = tgt;
				endcase
			end
			if (!settled_o && mode_i[0] && !hit) begin
				s_d.tmo = s_q.tmo + 10'h001;
			end else begin
				s_d.tmo = '0;
			end
			s_d.out = (s_q.att >= vtc_pkg::VTC_ATT_MUTE) ? '0 : prod[23:0];
		end
		if (force_imm_i) begin
			s_d.att = tgt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : vtc_chan

// >>> src/vtc_top.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - single-volume set: all channels use channel 0 volume register.
// - mode 00 applies every level or mute change at once.
// - mode 01 applies pending change at that channel's zero crossing.
// - mode 01 forces pending change after 512 samples without crossing.
// - mode 10 ramps 1/8 dB per sample period, 1 dB per 8.
// - mode 11 takes each 1/8 dB step on crossing or timeout.
// - auto-mute enabled mutes channel after 8192 static zero or minus-one samples.
// - one non-static sample releases auto-mute.
// - static detection and auto-mute are per channel.
// - mute indicator active while auto-mute holds.
// - auto-mute entry and exit follow the transition mode.
// - aux port mute bit silences the auxiliary serial port.
// - un-mute after filter, ratio or mode events; follows transition mode if ramp-up set.
// - ramp-up clear: that un-mute is immediate.
// - mute before filter or de-emphasis change; follows transition mode if ramp-down set.
// - ramp-down clear: that mute is immediate.
// - volume in 0.5 dB steps to -127 dB, below that mutes.
// - per-channel mute bit mutes via transition mode.
module vtc_top (
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // sync reset, active low
	input wire logic [7:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // register write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after strobe
	input wire logic smp_valid_i, // one pulse per sample period
	input wire logic [5:0][23:0] smp_i, // dac samples in
	output logic smp_valid_o, // output sample strobe
	output logic [5:0][23:0] smp_o, // dac samples to modulators
	input wire logic aux_valid_i, // aux port sample strobe
	input wire logic [23:0] aux_i, // aux port sample
	output logic aux_valid_o, // aux output strobe
	output logic [23:0] aux_o, // aux sample, zero when muted
	input wire logic filt_req_i, // filter mode change request
	input wire logic deemph_req_i, // de-emphasis change request
	input wire logic ratio_evt_i, // clock ratio change or error
	input wire logic func_evt_i, // functional mode change
	output logic change_apply_o, // pulse: outputs muted, apply change
	output logic mute_indicator_o // auto-mute indicator
);
	vtc_pkg::vtc_top_st_t s_q, s_d;
	logic [5:0] automute;
	logic [5:0] settled;
	logic [5:0][10:0] target;
	logic force_imm;
	logic sys_mute;
	logic [1:0] mode;
	logic [2:0] vidx;
	logic in_vol;

	assign mode = s_q.ctrl[vtc_pkg::VTC_BIT_MODE_HI:vtc_pkg::VTC_BIT_MODE_LO];
	assign in_vol = (addr_i >= vtc_pkg::VTC_ADDR_VOL0) && (addr_i <= vtc_pkg::VTC_ADDR_VOL5);
	assign vidx = 3'(addr_i - vtc_pkg::VTC_ADDR_VOL0);
	assign rdata_o = s_q.rdata;
	assign smp_valid_o = s_q.valid;
	assign aux_o = s_q.aux;
	assign aux_valid_o = s_q.aux_valid;
	assign change_apply_o = s_q.change_apply;
	assign mute_indicator_o = s_q.mute_ind;

	// ==========================================================
	// per-channel targets
	always_comb begin
		logic [7:0] v;
		v = '0;
		sys_mute = (s_q.seq == vtc_pkg::VTC_MUTING);
		for (int i = 0; i < vtc_pkg::VTC_NCH; i++) begin
			v = s_q.ctrl[vtc_pkg::VTC_BIT_SINGLE_VOLUME_SELECT] ? s_q.vol[0] : s_q.vol[i];
			if (s_q.chmute[i] || sys_mute || v > vtc_pkg::VTC_VOL_MAX) begin
				target[i] = vtc_pkg::VTC_ATT_MUTE;
			end else begin
				target[i] = {1'b0, v, 2'b00};
			end
		end
	end

	// ==========================================================
	// forced immediate steps around mode changes
	always_comb begin
		case (s_q.seq)
			vtc_pkg::VTC_MUTING:
				force_imm = !s_q.kind_apply || !s_q.ctrl[vtc_pkg::VTC_BIT_RMPDN];
			vtc_pkg::VTC_UNMUTE:
				force_imm = !s_q.ctrl[vtc_pkg::VTC_BIT_RMPUP];
			default:
				force_imm = 1'b0;
		endcase
	end

	// ==========================================================
	// channels
	for (genvar g = 0; g < vtc_pkg::VTC_NCH; g++) begin : g_ch
		vtc_chan u_chan (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.smp_stb_i(smp_valid_i),
			.smp_i(smp_i[g]),
			.mode_i(mode),
			.auto_static_mute_en_i(s_q.ctrl[vtc_pkg::VTC_BIT_AUTO_STATIC_MUTE]),
			.target_i(target[g]),
			.force_imm_i(force_imm),
			.smp_o(smp_o[g]),
			.automute_o(automute[g]),
			.settled_o(settled[g])
		);
	end

	// ==========================================================
	// registers, sequencer, aux path
	always_comb begin
		s_d = s_q;
		s_d.change_apply = 1'b0;
		s_d.valid = smp_valid_i;
		s_d.aux_valid = aux_valid_i;
		s_d.mute_ind = |automute;
		if (aux_valid_i) begin
			s_d.aux = s_q.ctrl[vtc_pkg::VTC_BIT_AUXMUTE] ? '0 : aux_i;
		end
		// register writes
		if (wr_i) begin
			if (addr_i == vtc_pkg::VTC_ADDR_CTRL) begin
				s_d.ctrl = wdata_i & vtc_pkg::VTC_CTRL_WMASK;
			end else if (addr_i == vtc_pkg::VTC_ADDR_CHMUTE) begin
				s_d.chmute = wdata_i[5:0];
			end else if (in_vol) begin
				s_d.vol[vidx] = wdata_i;
			end
		end
		// register reads
		s_d.rdata = '0;
		if (rd_i) begin
			if (addr_i == vtc_pkg::VTC_ADDR_CTRL) begin
				s_d.rdata = s_q.ctrl;
			end else if (addr_i == vtc_pkg::VTC_ADDR_CHMUTE) begin
				s_d.rdata = {2'b00, s_q.chmute};
			end else if (in_vol) begin
				s_d.rdata = s_q.vol[vidx];
			end else if (addr_i == vtc_pkg::VTC_ADDR_AMSTAT) begin
				s_d.rdata = {2'b00, automute};
			end else if (addr_i == vtc_pkg::VTC_ADDR_SEQSTAT) begin
				s_d.rdata = {s_q.seq, settled};
			end
		end
		// requests arriving while busy wait their turn
		if (filt_req_i || deemph_req_i) begin
			s_d.pend_filt = 1'b1;
		end
		if (ratio_evt_i || func_evt_i) begin
			s_d.pend_err = 1'b1;
		end
		case (s_q.seq)
			vtc_pkg::VTC_IDLE: begin
				if (s_q.pend_filt) begin
					s_d.seq = vtc_pkg::VTC_MUTING;
					s_d.kind_apply = 1'b1;
					s_d.pend_filt = filt_req_i || deemph_req_i;
				end else if (s_q.pend_err) begin
					s_d.seq = vtc_pkg::VTC_MUTING;
					s_d.kind_apply = 1'b0;
					s_d.pend_err = ratio_evt_i || func_evt_i;
				end
			end
			vtc_pkg::VTC_MUTING: begin
				if (&settled) begin
					s_d.seq = vtc_pkg::VTC_APPLY;
				end
			end
			vtc_pkg::VTC_APPLY: begin
				s_d.change_apply = s_q.kind_apply;
				s_d.seq = vtc_pkg::VTC_UNMUTE;
			end
			vtc_pkg::VTC_UNMUTE: begin
				if (&settled) begin
					s_d.seq = vtc_pkg::VTC_IDLE;
				end
			end
			default: s_d.seq = vtc_pkg::VTC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.ctrl <= vtc_pkg::VTC_CTRL_RST;
			s_q.chmute <= vtc_pkg::VTC_CHMUTE_RST;
			s_q.vol <= {vtc_pkg::VTC_NCH{vtc_pkg::VTC_VOL_RST}};
			s_q.seq <= vtc_pkg::VTC_IDLE;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : vtc_top

// >>> tb/vtc_sap_model.sv
`timescale 1ns/1ps
module vtc_sap_model (
	input wire logic clk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic quiet_i, // send static data
	input wire logic steady_i, // send constant positive data
	output logic smp_valid_o, // sample strobe
	output logic [5:0][23:0] smp_o // samples
);
	logic [1:0] div_q;
	// ==========================================================
	// one sample every four cycles, lines toggle between strobes
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_q <= 2'h0;
			smp_valid_o <= 1'b0;
			smp_o <= '0;
		end else begin
			div_q <= div_q + 2'h1;
			smp_valid_o <= (div_q == 2'h3);
			for (int g = 0; g < 6; g++) begin
				if (div_q != 2'h3) smp_o[g] <= ~smp_o[g];
				else if (quiet_i) smp_o[g] <= 24'h0;
				else if (steady_i) smp_o[g] <= 24'h001000;
				else smp_o[g] <= 24'($urandom);
			end
		end
	end
endmodule : vtc_sap_model

// >>> tb/vtc_top_chk.sv
`timescale 1ns/1ps
module vtc_top_chk (
	input wire logic clk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic [7:0] addr_i, // address
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write
	input wire logic rd_i, // read
	input wire logic [7:0] rdata_o, // read data
	input wire logic smp_valid_i, // sample strobe
	input wire logic [5:0][23:0] smp_i, // samples in
	input wire logic smp_valid_o, // strobe out
	input wire logic [5:0][23:0] smp_o, // samples out
	input wire logic aux_valid_i, // aux strobe
	input wire logic [23:0] aux_i, // aux in
	input wire logic [23:0] aux_o, // aux out
	input wire logic filt_req_i, // filter request
	input wire logic change_apply_o, // apply pulse
	input wire logic mute_indicator_o // indicator
);
	logic [7:0] ctrl_q;
	logic [13:0] st_cnt_q;
	logic st0;
	logic all_live;
	assign st0 = (smp_i[0] == 24'h0) || (smp_i[0] == 24'hffffff);
	always_comb begin
		all_live = 1'b1;
		for (int g = 0; g < 6; g++) begin
			if (smp_i[g] == 24'h0 || smp_i[g] == 24'hffffff) all_live = 1'b0;
		end
	end
	// ==========================================================
	// shadow of control and static run on channel 0
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl_q <= vtc_pkg::VTC_CTRL_RST;
			st_cnt_q <= 14'h0;
		end else begin
			if (wr_i && addr_i == vtc_pkg::VTC_ADDR_CTRL) ctrl_q <= wdata_i & 8'h7f;
			if (smp_valid_i) st_cnt_q <= !st0 ? 14'h0 : st_cnt_q[13] ? st_cnt_q : st_cnt_q + 14'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
	property p_rd_ctrl; rd_i && addr_i == vtc_pkg::VTC_ADDR_CTRL |=> rdata_o == ctrl_q; endproperty
	property p_vld; smp_valid_o == $past(smp_valid_i); endproperty
	property p_hold; !smp_valid_i |=> $stable(smp_o); endproperty
	property p_aux_mute; aux_valid_i && ctrl_q[2] |=> aux_o == 24'h0; endproperty
	property p_aux_pass; aux_valid_i && !ctrl_q[2] |=> aux_o == $past(aux_i); endproperty
	property p_apply; change_apply_o |=> !change_apply_o [*2]; endproperty
	property p_apply_imm; filt_req_i && ctrl_q[1:0] == 2'h0 |-> ##[1:40] change_apply_o; endproperty
	property p_am_set; smp_valid_i && st0 && st_cnt_q == 14'h1fff && ctrl_q[3] |-> ##[1:2] mute_indicator_o; endproperty
	property p_am_rel; smp_valid_i && all_live |-> ##[1:2] !mute_indicator_o; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl readback");
	a_vld: assert property (p_vld) else $error("sample strobe delay");
	a_hold: assert property (p_hold) else $error("sample moved");
	a_aux_mute: assert property (p_aux_mute) else $error("aux not muted");
	a_aux_pass: assert property (p_aux_pass) else $error("aux not passed");
	a_apply: assert property (p_apply) else $error("apply pulse long");
	a_apply_imm: assert property (p_apply_imm) else $error("apply late");
	a_am_set: assert property (p_am_set) else $error("auto-mute missing");
	a_am_rel: assert property (p_am_rel) else $error("auto-mute held");
	c_am: cover property ($rose(mute_indicator_o));
	c_apply: cover property (change_apply_o);
	c_aux: cover property (aux_valid_i && ctrl_q[2]);
endmodule : vtc_top_chk
bind vtc_top vtc_top_chk u_vtc_top_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .smp_valid_i(smp_valid_i),
	.smp_i(smp_i), .smp_valid_o(smp_valid_o), .smp_o(smp_o), .aux_valid_i(aux_valid_i),
	.aux_i(aux_i), .aux_o(aux_o), .filt_req_i(filt_req_i), .change_apply_o(change_apply_o),
	.mute_indicator_o(mute_indicator_o));

// >>> tb/vtc_top_tb.sv
`timescale 1ns/1ps
module vtc_top_tb;
	localparam logic [7:0] A_CTRL = vtc_pkg::VTC_ADDR_CTRL;
	localparam logic [7:0] A_VOL = vtc_pkg::VTC_ADDR_VOL0;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	logic wr_i = 1'b0, rd_i = 1'b0, smp_valid_i, smp_valid_o, aux_valid_i = 1'b0, aux_valid_o;
	logic [5:0][23:0] smp_i, smp_o;
	logic [23:0] aux_i = 24'h0, aux_o;
	logic [3:0] evt = 4'h0;
	logic [5:0] m;
	logic change_apply_o, mute_indicator_o, quiet = 1'b0, steady = 1'b0;
	int fail_count = 0, checked = 0;
	always #5 clk_i = ~clk_i;
	vtc_sap_model u_vtc_sap_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .quiet_i(quiet),
		.steady_i(steady), .smp_valid_o(smp_valid_i), .smp_o(smp_i));
	vtc_top u_vtc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .smp_valid_i(smp_valid_i), .smp_i(smp_i),
		.smp_valid_o(smp_valid_o), .smp_o(smp_o), .aux_valid_i(aux_valid_i), .aux_i(aux_i),
		.aux_valid_o(aux_valid_o), .aux_o(aux_o), .filt_req_i(evt[0]), .deemph_req_i(evt[1]),
		.ratio_evt_i(evt[2]), .func_evt_i(evt[3]), .change_apply_o(change_apply_o),
		.mute_indicator_o(mute_indicator_o));
	task wrap_up;
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk({16'h0, rdata_o}, {16'h0, e});
	endtask : rd
	task smp(input int n);
		repeat (n) begin
			do begin
				@(posedge clk_i);
				#1;
			end while (smp_valid_i !== 1'b1);
		end
	endtask : smp
	// ==========================================================
	// expected sample: shifted input or silence per channel
	task gain(input int sh, input logic [5:0] mk);
		logic [5:0][23:0] s;
		smp(1);
		s = smp_i;
		@(posedge clk_i);
		#1;
		for (int g = 0; g < 6; g++) chk(smp_o[g], mk[g] ? 24'h0 : 24'($signed(s[g]) >>> sh));
	endtask : gain
	task evt_run(input int i, input int lo, input int hi, input int e);
		int n_lo, n;
		n_lo = 0;
		n = 0;
		@(posedge clk_i);
		evt <= 4'h1 << i;
		@(posedge clk_i);
		evt <= 4'h0;
		for (int c = 0; c < hi; c++) begin
			@(posedge clk_i);
			#1;
			if (change_apply_o === 1'b1) n++;
			if (change_apply_o === 1'b1 && c < lo) n_lo++;
		end
		chk(24'(n_lo), 24'h0);
		chk(24'(n), 24'(e));
	endtask : evt_run
	initial begin
		#700000;
		fail_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(81397));
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(A_CTRL, vtc_pkg::VTC_CTRL_RST);
		rd(8'h55, 8'h00);
		wr(A_CTRL, 8'hff);
		rd(A_CTRL, 8'h7f);
		wr(A_CTRL, 8'h08);
		smp(2);
		gain(0, 6'h00);
		wr(A_VOL, 8'h60);
		for (int i = 1; i < 6; i++) wr(A_VOL + 8'(i), 8'($urandom));
		wr(A_CTRL, 8'h48);
		smp(2);
		gain(8, 6'h00);
		wr(A_CTRL, 8'h08);
		wr(A_VOL, 8'hff);
		for (int i = 1; i < 6; i++) wr(A_VOL + 8'(i), 8'h00);
		smp(2);
		gain(0, 6'h01);
		m = 6'($urandom);
		wr(vtc_pkg::VTC_ADDR_CHMUTE, {2'h0, m});
		wr(A_VOL, 8'h00);
		smp(2);
		gain(0, m);
		wr(vtc_pkg::VTC_ADDR_CHMUTE, 8'h00);
		wr(A_CTRL, 8'h28);
		wr(A_VOL, 8'h02);
		smp(4);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3e);
		smp(6);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3f);
		steady <= 1'b1;
		wr(A_CTRL, 8'h18);
		smp(4);
		wr(A_VOL, 8'h06);
		smp(500);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3e);
		smp(20);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3f);
		steady <= 1'b0;
		wr(A_VOL, 8'h02);
		smp(40);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3f);
		wr(A_CTRL, 8'h38);
		wr(A_VOL, 8'h04);
		smp(3);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3e);
		smp(200);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3f);
		for (int k = 0; k < 2; k++) begin
			wr(A_CTRL, k ? 8'h0c : 8'h08);
			@(posedge clk_i);
			aux_i <= 24'($urandom);
			aux_valid_i <= 1'b1;
			@(posedge clk_i);
			aux_valid_i <= 1'b0;
			#1;
			chk(aux_o, k ? 24'h0 : aux_i);
			chk({23'h0, aux_valid_o}, 24'h1);
		end
		wr(A_CTRL, 8'h28);
		evt_run(0, 0, 100, 1);
		rd(vtc_pkg::VTC_ADDR_SEQSTAT, 8'h3f);
		wr(A_CTRL, 8'h08);
		for (int i = 0; i < 4; i++) evt_run(i, 0, 100, i < 2);
		quiet <= 1'b1;
		smp(8100);
		chk({23'h0, mute_indicator_o}, 24'h0);
		smp(100);
		chk({23'h0, mute_indicator_o}, 24'h1);
		rd(vtc_pkg::VTC_ADDR_AMSTAT, 8'h3f);
		quiet <= 1'b0;
		smp(2);
		chk({23'h0, mute_indicator_o}, 24'h0);
		wr(A_CTRL, 8'h2b);
		evt_run(0, 1000, 9000, 1);
		wrap_up();
	end
endmodule : vtc_top_tb
